// file: ifs_irq_sleep_ctrl.sv
// interrupt request flags and power-down control registers
`timescale 1ns/1ps
//
// Overview of operation
// - direct-transition flag bit 7 sets on sleep with direct transfer enabled; write 0 clears.
// - line 3 flag bit 3 sets on selected edge when pin is interrupt input.
// - line 0 flag bit 0 sets on selected edge when pin is interrupt input.
// - flag register bits 5 and 4 read one; bits 6, 2 and 1 read zero.
// - sleep mode select, direct transfer enable and standby select choose sleep target.
// - active clock select bits 4..2 take effect only after sleep instruction.
// - clock select 0xx undivided, 100 divide by 8, 101 divide by 16.
// - control register two bits 6, 1 and 0 read zero.
module ifs_irq_sleep_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [ifs_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ifs_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ifs_pkg::DATA_W-1:0] reg_rdata,
	// external interrupt pins
	input wire logic ext_interrupt_line0,
	input wire logic ext_interrupt_line3,
	// processor core
	input wire logic sleep_exec,
	// power state
	output logic [1:0] op_mode,
	output logic [2:0] clk_sel,
	output logic [4:0] clk_div_ratio,
	output logic direct_transition,
	// interrupt
	output logic irq
);
	// software-visible state
	logic flag_dt_ff;
	logic flag_l3_ff;
	logic flag_l0_ff;
	logic sleep_mode_select_ff;
	logic direct_transfer_enable_ff;
	logic [2:0] ma_ff;
	logic standby_select_ff;
	logic [3:0] pincfg_ff;
	logic [ifs_pkg::EVT_N-1:0] mask_ff;

	// operating state
	ifs_pkg::ifs_mode_e mode_ff;
	ifs_pkg::ifs_mode_e nxt_mode;
	logic [2:0] clk_sel_ff;
	logic [4:0] ratio_ff;
	logic direct_ff;
	logic irq_ff;
	logic [ifs_pkg::DATA_W-1:0] rdata_ff;
	logic [ifs_pkg::DATA_W-1:0] nxt_rdata;

	// decoded access strobes
	logic wr_flags;
	logic wr_pdc2;
	logic wr_pdc1;
	logic wr_pincfg;
	logic wr_stat;
	logic wr_mask;

	// events
	logic edge_l0;
	logic edge_l3;
	logic set_l0;
	logic set_l3;
	logic sleep_ok;
	logic set_dt;
	logic [ifs_pkg::EVT_N-1:0] evt_vec;
	logic [ifs_pkg::EVT_N-1:0] clr_vec;
	logic [ifs_pkg::EVT_N-1:0] stat_vec;
	logic irq_comb;

	// assembled register images
	logic [7:0] flags_img;
	logic [7:0] pdc2_img;
	logic [7:0] pdc1_img;
	logic [7:0] mode_img;

	assign wr_flags = reg_wr && (reg_addr == ifs_pkg::OFF_FLAGS);
	assign wr_pdc2 = reg_wr && (reg_addr == ifs_pkg::OFF_PDC2);
	assign wr_pdc1 = reg_wr && (reg_addr == ifs_pkg::OFF_PDC1);
	assign wr_pincfg = reg_wr && (reg_addr == ifs_pkg::OFF_PINCFG);
	assign wr_stat = reg_wr && (reg_addr == ifs_pkg::OFF_INT_STAT);
	assign wr_mask = reg_wr && (reg_addr == ifs_pkg::OFF_INT_MASK);

	// pin edge detection; pins are asynchronous, so both pass two flops first
	ifs_edge_det u_edge_l0 (
		.clk(clk),
		.reset(reset),
		.pin(ext_interrupt_line0),
		.rise_sel(pincfg_ff[ifs_pkg::PCFG_L0_RISE]),
		.edge_pulse(edge_l0)
	);

	ifs_edge_det u_edge_l3 (
		.clk(clk),
		.reset(reset),
		.pin(ext_interrupt_line3),
		.rise_sel(pincfg_ff[ifs_pkg::PCFG_L3_RISE]),
		.edge_pulse(edge_l3)
	);

	// an edge only counts while the pin serves as an interrupt input
	assign set_l0 = edge_l0 && pincfg_ff[ifs_pkg::PCFG_L0_EN];
	assign set_l3 = edge_l3 && pincfg_ff[ifs_pkg::PCFG_L3_EN];

	// a sleep instruction is only meaningful from active mode
	assign sleep_ok = sleep_exec && (mode_ff == ifs_pkg::MODE_ACTIVE);
	assign set_dt = sleep_ok && direct_transfer_enable_ff;

	// request flags: hardware set wins; only a written 0 clears
	always_ff @(posedge clk)
	begin
		if (reset)
			flag_dt_ff <= ifs_pkg::RST_FLAGS[ifs_pkg::FLG_DT];
		else if (set_dt)
			flag_dt_ff <= 1'b1;
		else if (wr_flags && !reg_wdata[ifs_pkg::FLG_DT])
			flag_dt_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			flag_l3_ff <= ifs_pkg::RST_FLAGS[ifs_pkg::FLG_L3];
		else if (set_l3)
			flag_l3_ff <= 1'b1;
		else if (wr_flags && !reg_wdata[ifs_pkg::FLG_L3])
			flag_l3_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			flag_l0_ff <= ifs_pkg::RST_FLAGS[ifs_pkg::FLG_L0];
		else if (set_l0)
			flag_l0_ff <= 1'b1;
		else if (wr_flags && !reg_wdata[ifs_pkg::FLG_L0])
			flag_l0_ff <= 1'b0;
	end

	// power_down_control_two
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sleep_mode_select_ff <= ifs_pkg::RST_PDC2[ifs_pkg::PDC2_SLEEP_MODE_SELECT];
			direct_transfer_enable_ff <= ifs_pkg::RST_PDC2[ifs_pkg::PDC2_DIRECT_TRANSFER_ENABLE];
			ma_ff <= ifs_pkg::RST_PDC2[ifs_pkg::PDC2_MA_HI:ifs_pkg::PDC2_MA_LO];
		end
		else if (wr_pdc2)
		begin
			sleep_mode_select_ff <= reg_wdata[ifs_pkg::PDC2_SLEEP_MODE_SELECT];
			direct_transfer_enable_ff <= reg_wdata[ifs_pkg::PDC2_DIRECT_TRANSFER_ENABLE];
			ma_ff <= reg_wdata[ifs_pkg::PDC2_MA_HI:ifs_pkg::PDC2_MA_LO];
		end
	end

	// power_down_control_one, standby select only
	always_ff @(posedge clk)
	begin
		if (reset)
			standby_select_ff <= ifs_pkg::RST_PDC1[ifs_pkg::PDC1_STANDBY_SELECT];
		else if (wr_pdc1)
			standby_select_ff <= reg_wdata[ifs_pkg::PDC1_STANDBY_SELECT];
	end

	// pin interrupt configuration
	always_ff @(posedge clk)
	begin
		if (reset)
			pincfg_ff <= ifs_pkg::RST_PINCFG;
		else if (wr_pincfg)
			pincfg_ff <= reg_wdata[3:0];
	end

	// interrupt mask
	always_ff @(posedge clk)
	begin
		if (reset)
			mask_ff <= ifs_pkg::RST_MASK;
		else if (wr_mask)
			mask_ff <= reg_wdata[ifs_pkg::EVT_N-1:0];
	end

	// sticky event status, cleared by writing one
	always_comb
	begin
		evt_vec = '0;
		evt_vec[ifs_pkg::EVT_DT] = set_dt;
		evt_vec[ifs_pkg::EVT_L3] = set_l3;
		evt_vec[ifs_pkg::EVT_L0] = set_l0;
		clr_vec = wr_stat ? reg_wdata[ifs_pkg::EVT_N-1:0] : '0;
	end

	ifs_sticky_status u_status (
		.clk(clk),
		.reset(reset),
		.evt(evt_vec),
		.clr(clr_vec),
		.mask(mask_ff),
		.status(stat_vec),
		.irq_any(irq_comb)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
			irq_ff <= 1'b0;
		else
			irq_ff <= irq_comb;
	end

	// target of a sleep instruction; direct transfer keeps the core running
	always_comb
	begin
		nxt_mode = mode_ff;
		case (mode_ff)
			ifs_pkg::MODE_ACTIVE:
			begin
				if (sleep_ok && !direct_transfer_enable_ff)
				begin
					if (standby_select_ff)
						nxt_mode = ifs_pkg::MODE_STANDBY;
					else if (sleep_mode_select_ff)
						nxt_mode = ifs_pkg::MODE_SUBSLEEP;
					else
						nxt_mode = ifs_pkg::MODE_SLEEP;
				end
			end
			ifs_pkg::MODE_SLEEP,
			ifs_pkg::MODE_SUBSLEEP,
			ifs_pkg::MODE_STANDBY:
			begin
				// wake only on a pin request; the direct flag cannot fire here
				if (set_l0 || set_l3)
					nxt_mode = ifs_pkg::MODE_ACTIVE;
			end
			default:
				nxt_mode = ifs_pkg::MODE_ACTIVE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			mode_ff <= ifs_pkg::MODE_ACTIVE;
		else
			mode_ff <= nxt_mode;
	end

	// one-cycle marker of a direct transition
	always_ff @(posedge clk)
	begin
		if (reset)
			direct_ff <= 1'b0;
		else
			direct_ff <= set_dt;
	end

	// operating clock select: a new field value waits for a sleep instruction,
	// so a write alone never disturbs the running clock
	always_ff @(posedge clk)
	begin
		if (reset)
			clk_sel_ff <= ifs_pkg::RST_CLK_SEL;
		else if (sleep_ok)
			clk_sel_ff <= ma_ff;
	end

	// divide ratio decode; the undefined 11x codes fall back to undivided
	always_ff @(posedge clk)
	begin
		if (reset)
			ratio_ff <= ifs_pkg::RATIO_1;
		else if (sleep_ok)
		begin
			case (ma_ff)
				ifs_pkg::MA_DIV8: ratio_ff <= ifs_pkg::RATIO_8;
				ifs_pkg::MA_DIV16: ratio_ff <= ifs_pkg::RATIO_16;
				default: ratio_ff <= ifs_pkg::RATIO_1;
			endcase
		end
	end

	// register images with fixed reserved bits
	always_comb
	begin
		flags_img = ifs_pkg::FLG_FIXED_ONES;
		flags_img[ifs_pkg::FLG_DT] = flag_dt_ff;
		flags_img[ifs_pkg::FLG_L3] = flag_l3_ff;
		flags_img[ifs_pkg::FLG_L0] = flag_l0_ff;
		pdc2_img = '0;
		pdc2_img[ifs_pkg::PDC2_SLEEP_MODE_SELECT] = sleep_mode_select_ff;
		pdc2_img[ifs_pkg::PDC2_DIRECT_TRANSFER_ENABLE] = direct_transfer_enable_ff;
		pdc2_img[ifs_pkg::PDC2_MA_HI:ifs_pkg::PDC2_MA_LO] = ma_ff;
		pdc1_img = '0;
		pdc1_img[ifs_pkg::PDC1_STANDBY_SELECT] = standby_select_ff;
		mode_img = {1'b0, clk_sel_ff, 2'b00, mode_ff};
	end

	// read mux; unmapped offsets answer zero
	always_comb
	begin
		nxt_rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				ifs_pkg::OFF_FLAGS: nxt_rdata = flags_img;
				ifs_pkg::OFF_PDC2: nxt_rdata = pdc2_img;
				ifs_pkg::OFF_PDC1: nxt_rdata = pdc1_img;
				ifs_pkg::OFF_PINCFG: nxt_rdata = {4'h0, pincfg_ff};
				ifs_pkg::OFF_INT_STAT: nxt_rdata = {5'h00, stat_vec};
				ifs_pkg::OFF_INT_MASK: nxt_rdata = {5'h00, mask_ff};
				ifs_pkg::OFF_MODE_STAT: nxt_rdata = mode_img;
				default: nxt_rdata = '0;
			endcase
		end
	end

	// read data stand one cycle after the strobe and are zero otherwise
	always_ff @(posedge clk)
	begin
		if (reset)
			rdata_ff <= '0;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;
	assign op_mode = mode_ff;
	assign clk_sel = clk_sel_ff;
	assign clk_div_ratio = ratio_ff;
	assign direct_transition = direct_ff;
	assign irq = irq_ff;
endmodule : ifs_irq_sleep_ctrl

// file: ifs_pkg.sv
// constants and types shared by the interrupt flag and sleep control block
package ifs_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int EVT_N = 3;
	// register offsets
	localparam logic [3:0] OFF_FLAGS = 4'h0;
	localparam logic [3:0] OFF_PDC2 = 4'h1;
	localparam logic [3:0] OFF_PDC1 = 4'h2;
	localparam logic [3:0] OFF_PINCFG = 4'h3;
	localparam logic [3:0] OFF_INT_STAT = 4'h4;
	localparam logic [3:0] OFF_INT_MASK = 4'h5;
	localparam logic [3:0] OFF_MODE_STAT = 4'h6;
	// interrupt_request_flags fields
	localparam int FLG_DT = 7;
	localparam int FLG_L3 = 3;
	localparam int FLG_L0 = 0;
	localparam logic [7:0] FLG_FIXED_ONES = 8'h30;
	// power_down_control_two fields
	localparam int PDC2_SLEEP_MODE_SELECT = 7;
	localparam int PDC2_DIRECT_TRANSFER_ENABLE = 5;
	localparam int PDC2_MA_HI = 4;
	localparam int PDC2_MA_LO = 2;
	// power_down_control_one field
	localparam int PDC1_STANDBY_SELECT = 7;
	// pin configuration fields
	localparam int PCFG_L0_EN = 0;
	localparam int PCFG_L0_RISE = 1;
	localparam int PCFG_L3_EN = 2;
	localparam int PCFG_L3_RISE = 3;
	// event status bits
	localparam int EVT_DT = 0;
	localparam int EVT_L3 = 1;
	localparam int EVT_L0 = 2;
	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_PDC2 = 8'h00;
	localparam logic [7:0] RST_PDC1 = 8'h00;
	localparam logic [3:0] RST_PINCFG = 4'h0;
	localparam logic [2:0] RST_MASK = 3'h0;
	localparam logic [2:0] RST_CLK_SEL = 3'h0;
	// active clock select codes
	localparam logic [2:0] MA_DIV8 = 3'h4;
	localparam logic [2:0] MA_DIV16 = 3'h5;
	localparam logic [4:0] RATIO_1 = 5'h01;
	localparam logic [4:0] RATIO_8 = 5'h08;
	localparam logic [4:0] RATIO_16 = 5'h10;
	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_SLEEP,
		MODE_SUBSLEEP,
		MODE_STANDBY
	} ifs_mode_e;
endpackage : ifs_pkg

// file: ifs_edge_det.sv
// pin synchroniser with selectable edge detection
`timescale 1ns/1ps
module ifs_edge_det (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// pin and selection
	input wire logic pin,
	input wire logic rise_sel,
	// detected edge
	output logic edge_pulse
);
	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;

	// first stage feeds only the second stage to keep metastability contained
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff <= 1'b1;
		end
		else
		begin
			sync1_ff <= pin;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	always_comb
	begin
		if (rise_sel)
			edge_pulse = sync2_ff & ~prev_ff;
		else
			edge_pulse = ~sync2_ff & prev_ff;
	end
endmodule : ifs_edge_det

// file: ifs_sticky_status.sv
// sticky event status bits with write-one-to-clear and mask
`timescale 1ns/1ps
module ifs_sticky_status (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// events and software access
	input wire logic [ifs_pkg::EVT_N-1:0] evt,
	input wire logic [ifs_pkg::EVT_N-1:0] clr,
	input wire logic [ifs_pkg::EVT_N-1:0] mask,
	// state
	output logic [ifs_pkg::EVT_N-1:0] status,
	output logic irq_any
);
	genvar i;
	generate
		for (i = 0; i < ifs_pkg::EVT_N; i++)
		begin : g_bit
			logic bit_ff;
			// set wins over a clear in the same cycle
			always_ff @(posedge clk)
			begin
				if (reset)
					bit_ff <= 1'b0;
				else if (evt[i])
					bit_ff <= 1'b1;
				else if (clr[i])
					bit_ff <= 1'b0;
			end
			assign status[i] = bit_ff;
		end
	endgenerate

	assign irq_any = |(status & mask);
endmodule : ifs_sticky_status

// file: ifs_far_side_model.sv
// far-side model: interrupt pins with pull-ups and the core sleep strobe
`timescale 1ns/1ps
module ifs_far_side_model (
	// clock
	input wire logic clk,
	// pins and core strobe
	output logic ext_interrupt_line0,
	output logic ext_interrupt_line3,
	output logic sleep_exec
);
	// pins idle high as if pulled up, so a released pin never floats
	initial
	begin
		ext_interrupt_line0 = 1'b1;
		ext_interrupt_line3 = 1'b1;
		sleep_exec = 1'b0;
	end
	// low phase of at least two clocks, else the synchroniser may miss it
	task pin_pulse(input logic line3, input int low_cycles);
		@(posedge clk);
		if (line3)
			ext_interrupt_line3 <= 1'b0;
		else
			ext_interrupt_line0 <= 1'b0;
		repeat (low_cycles) @(posedge clk);
		ext_interrupt_line3 <= 1'b1;
		ext_interrupt_line0 <= 1'b1;
	endtask : pin_pulse
	task sleep_once;
		@(posedge clk);
		sleep_exec <= 1'b1;
		@(posedge clk);
		sleep_exec <= 1'b0;
	endtask : sleep_once
endmodule : ifs_far_side_model

// file: ifs_irq_sleep_ctrl_monitor.sv
// assertion checker for the flag and sleep control block
`timescale 1ns/1ps
module ifs_irq_sleep_ctrl_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// watched ports
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sleep_exec,
	input wire logic [1:0] op_mode,
	input wire logic [2:0] clk_sel,
	input wire logic [4:0] clk_div_ratio,
	input wire logic direct_transition
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence rd_at(logic [3:0] off);
		reg_rd && reg_addr == off;
	endsequence
	sequence sleep_taken;
		sleep_exec && op_mode == ifs_pkg::MODE_ACTIVE;
	endsequence
	flags_fixed_a: assert property (rd_at(ifs_pkg::OFF_FLAGS) |=>
		reg_rdata[6:4] == 3'h3 && reg_rdata[2:1] == 2'h0) else $error("flag fixed bits wrong");
	ctrl_zero_a: assert property (rd_at(ifs_pkg::OFF_PDC2) |=>
		reg_rdata[6] == 1'b0 && reg_rdata[1:0] == 2'h0) else $error("control unused bits wrong");
	ratio_code_a: assert property (clk_div_ratio == (clk_sel == ifs_pkg::MA_DIV8 ?
		ifs_pkg::RATIO_8 : clk_sel == ifs_pkg::MA_DIV16 ? ifs_pkg::RATIO_16 : ifs_pkg::RATIO_1))
		else $error("divider ratio does not match code");
	sel_hold_a: assert property (!sleep_exec |=> $stable(clk_sel))
		else $error("clock select changed without sleep");
	sleep_outcome_a: assert property (sleep_taken |=>
		direct_transition != (op_mode != ifs_pkg::MODE_ACTIVE)) else $error("sleep outcome wrong");
	dt_cause_a: assert property (direct_transition |->
		$past(sleep_exec) && op_mode == ifs_pkg::MODE_ACTIVE) else $error("stray direct pulse");
	enter_cause_a: assert property (op_mode != ifs_pkg::MODE_ACTIVE &&
		$past(op_mode) == ifs_pkg::MODE_ACTIVE |-> $past(sleep_exec)) else $error("mode left alone");
	dt_single_a: assert property (sleep_taken ##1 direct_transition |=> !direct_transition)
		else $error("direct pulse too long");
endmodule : ifs_irq_sleep_ctrl_monitor

// file: tb_ifs_irq_sleep_ctrl.sv
// self-checking bench for the flag and sleep control block
`timescale 1ns/1ps
module tb_ifs_irq_sleep_ctrl;
	logic clk;
	logic reset;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic ext_interrupt_line0;
	logic ext_interrupt_line3;
	logic sleep_exec;
	logic [1:0] op_mode;
	logic [2:0] clk_sel;
	logic [4:0] clk_div_ratio;
	logic direct_transition;
	logic irq;
	logic rd_d;
	logic [7:0] exp_q[$];
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	ifs_irq_sleep_ctrl uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_interrupt_line0(ext_interrupt_line0), .ext_interrupt_line3(ext_interrupt_line3),
		.sleep_exec(sleep_exec), .op_mode(op_mode), .clk_sel(clk_sel),
		.clk_div_ratio(clk_div_ratio), .direct_transition(direct_transition), .irq(irq));
	ifs_far_side_model far (.clk(clk), .ext_interrupt_line0(ext_interrupt_line0),
		.ext_interrupt_line3(ext_interrupt_line3), .sleep_exec(sleep_exec));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task test_done;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd
	function automatic logic [4:0] ratio(input logic [2:0] c);
		if (c == ifs_pkg::MA_DIV8)
			return ifs_pkg::RATIO_8;
		if (c == ifs_pkg::MA_DIV16)
			return ifs_pkg::RATIO_16;
		return ifs_pkg::RATIO_1;
	endfunction : ratio
	// read data exist only in the cycle after the strobe, so compare there
	always @(posedge clk)
		rd_d <= reg_rd & ~reset;
	always @(negedge clk)
		if (rd_d === 1'b1)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			bad_count++;
			test_done;
		end
	end
	initial
	begin
		int unsigned r;
		logic [2:0] code;
		logic [2:0] prev;
		logic [1:0] m;
		reset = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		prev = 3'h0;
		r = $urandom(32'h87DAC626);
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(ifs_pkg::OFF_FLAGS, 8'h30);
		rd(ifs_pkg::OFF_PDC2, 8'h00);
		rd(4'hF, 8'h00);
		wr(ifs_pkg::OFF_FLAGS, 8'hFF);
		rd(ifs_pkg::OFF_FLAGS, 8'h30);
		wr(ifs_pkg::OFF_PDC2, 8'hFF);
		rd(ifs_pkg::OFF_PDC2, 8'hBC);
		far.pin_pulse(1'b0, 3);
		far.pin_pulse(1'b1, 3);
		repeat (6) @(posedge clk);
		rd(ifs_pkg::OFF_FLAGS, 8'h30);
		wr(ifs_pkg::OFF_PINCFG, 8'h05);
		for (int i = 0; i < 3; i++)
		begin
			wr(ifs_pkg::OFF_PDC1, {i == 0, 7'h00});
			wr(ifs_pkg::OFF_PDC2, {i == 1, 7'h00});
			m = i == 0 ? ifs_pkg::MODE_STANDBY : i == 1 ? ifs_pkg::MODE_SUBSLEEP : ifs_pkg::MODE_SLEEP;
			far.sleep_once;
			@(negedge clk);
			chk("op_mode", {6'h00, m}, {6'h00, op_mode});
			chk("direct_transition", 8'h00, {7'h00, direct_transition});
			rd(ifs_pkg::OFF_MODE_STAT, {6'h00, m});
			far.pin_pulse(i == 1, 3);
			repeat (6) @(posedge clk);
			rd(ifs_pkg::OFF_FLAGS, i == 1 ? 8'h38 : 8'h31);
			rd(ifs_pkg::OFF_MODE_STAT, 8'h00);
			wr(ifs_pkg::OFF_FLAGS, 8'h00);
			rd(ifs_pkg::OFF_FLAGS, 8'h30);
		end
		// rising edges selected on both lines; the falling half must not count
		wr(ifs_pkg::OFF_PINCFG, 8'h0F);
		far.pin_pulse(1'b0, 3);
		far.pin_pulse(1'b1, 3);
		repeat (6) @(posedge clk);
		rd(ifs_pkg::OFF_FLAGS, 8'h39);
		wr(ifs_pkg::OFF_FLAGS, 8'h00);
		@(negedge clk);
		// status is set by the pin events but masked off, so no interrupt
		chk("irq", 8'h00, {7'h00, irq});
		wr(ifs_pkg::OFF_INT_STAT, 8'h07);
		wr(ifs_pkg::OFF_INT_MASK, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			code = 3'(i);
			wr(ifs_pkg::OFF_PDC2, {1'($urandom), 2'b01, code, 2'b00});
			rd(ifs_pkg::OFF_MODE_STAT, {1'b0, prev, 4'h0});
			far.sleep_once;
			@(negedge clk);
			chk("direct_transition", 8'h01, {7'h00, direct_transition});
			chk("clk_sel", {5'h00, code}, {5'h00, clk_sel});
			chk("op_mode", 8'h00, {6'h00, op_mode});
			rd(ifs_pkg::OFF_MODE_STAT, {1'b0, code, 4'h0});
			rd(ifs_pkg::OFF_FLAGS, 8'hB0);
			@(negedge clk);
			chk("clk_div_ratio", {3'h0, ratio(code)}, {3'h0, clk_div_ratio});
			chk("irq", 8'h01, {7'h00, irq});
			wr(ifs_pkg::OFF_FLAGS, 8'h7F);
			rd(ifs_pkg::OFF_FLAGS, 8'h30);
			wr(ifs_pkg::OFF_INT_STAT, 8'h01);
			@(posedge clk);
			@(negedge clk);
			chk("irq", 8'h00, {7'h00, irq});
			prev = code;
		end
		test_done;
	end
endmodule : tb_ifs_irq_sleep_ctrl
bind ifs_irq_sleep_ctrl ifs_irq_sleep_ctrl_monitor u_mon (.clk(clk), .reset(reset),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
	.op_mode(op_mode), .clk_sel(clk_sel), .clk_div_ratio(clk_div_ratio),
	.direct_transition(direct_transition));
